// [rtl/scope_trigger_unit.v]
`timescale 1ns/10ps
`include "trig_consts.vh"

// Behaviour
// - Edge trigger fires on threshold crossing.
// - Direction picks rising or falling crossing.
// - Mode none captures continuously, no trigger.
// - Auto waits, then captures after timeout.
// - Repeat captures only after each trigger.
// - Single halts after first triggered capture.
// - Only selected source channel is evaluated.
// - Slow time base updates per sample.
// - Advanced edge adds dual-edge direction.
// - Hysteresis: second threshold arms, main fires.
// - Window fires entering, exiting, or either.
// - Threshold one upper, threshold two lower.
module scope_trigger_unit
#(
  parameter W = 12,
  parameter NCH = 4,
  parameter SRCW = 2,
  parameter CAPW = 16,
  parameter TOW = 24,
  parameter [TOW-1:0] AUTO_CYC = `AUTO_WAIT_CYC
)
(
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_smp_valid,
  input wire [NCH*W-1:0] i_smp_data,
  output reg [W-1:0] o_smp,
  output reg o_capture,
  output reg o_trig,
  output reg o_forced,
  output reg o_frame_done,
  output reg o_update,
  output reg o_halted
);

// ****************************************************************
// States.
// ****************************************************************
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_ARM = 2'h1;
localparam [1:0] ST_CAPT = 2'h2;
localparam [1:0] ST_HALT = 2'h3;

// ****************************************************************
// Reset values, cut to the width of each register.
// ****************************************************************
localparam [31:0] CTRL_RST_W = `CTRL_RST;
localparam [31:0] THR_RST_W = `THR_RST;
localparam [31:0] CAPLEN_RST_W = `CAPLEN_RST;

// ****************************************************************
// Register file.
// ****************************************************************
reg [10:0] ctrl_ff;
reg [W-1:0] thr1_ff;
reg [W-1:0] thr2_ff;
reg [TOW-1:0] auto_ff;
reg [CAPW-1:0] caplen_ff;
reg [15:0] frames_ff;
reg [W-1:0] trigval_ff;
reg trigd_ff;
reg forced_ff;
reg frame_trig_ff;
reg [1:0] state_ff;
reg [1:0] nxt_state;
reg [W-1:0] last_smp_ff;
reg [31:0] rdata;
reg mapped;

wire run = ctrl_ff[`CTRL_RUN];
wire [1:0] mode = ctrl_ff[`CTRL_MODE_LSB +: 2];
wire [1:0] ttype = ctrl_ff[`CTRL_TYPE_LSB +: 2];
wire [1:0] dir = ctrl_ff[`CTRL_DIR_LSB +: 2];
wire [SRCW-1:0] src = ctrl_ff[`CTRL_SRC_LSB +: SRCW];
wire hyst = ctrl_ff[`CTRL_HYST];
wire slow = ctrl_ff[`CTRL_SLOW];

// The write commits at the edge where the master sees pready high.
wire acc = i_psel && i_penable && !o_pready;
wire wr = i_psel && i_penable && o_pready && i_pwrite;
wire wr_ctrl = wr && (i_paddr == `REG_CTRL);
wire wr_cmd = wr && (i_paddr == `REG_CMD);
wire force_trig = wr_cmd && i_pwdata[`CMD_FORCE];
wire rearm = wr_cmd && i_pwdata[`CMD_REARM];

// ****************************************************************
// Source selection and detector.
// ****************************************************************
wire [W-1:0] sel_smp = i_smp_data[src*W +: W];
wire fire;
wire to_zero;
wire cap_zero;
wire cap_last;

// Thresholds reach the detector as raw register bits; it compares
// them as signed values, so negative levels work as expected.
trig_detect #(.W(W)) u_detect
(
  .i_ref_clk(i_ref_clk),
  .i_srst(i_srst),
  .i_valid(i_smp_valid),
  .i_smp(sel_smp),
  .i_thr1(thr1_ff),
  .i_thr2(thr2_ff),
  .i_type(ttype),
  .i_dir(dir),
  .i_hyst(hyst),
  .o_fire(fire)
);

// ****************************************************************
// Sequencer.
// ****************************************************************
wire in_arm = (state_ff == ST_ARM);
wire in_capt = (state_ff == ST_CAPT);
wire enter_arm = (nxt_state == ST_ARM) && !in_arm;
wire enter_capt = (nxt_state == ST_CAPT) && !in_capt;
wire frame_end = in_capt && i_smp_valid && (cap_last || cap_zero);
// Fires are only taken while waiting, so a crossing inside a frame
// cannot restart it; a forced trigger counts as a real one.
wire got_trig = in_arm && run && (mode != `MODE_NONE) && (fire || force_trig);
wire auto_exp = in_arm && run && (mode == `MODE_AUTO) && !got_trig
  && to_zero;
// A zero length is loaded as one, which gives the same one-sample frame that cap_zero would.
wire [CAPW-1:0] cap_load = (caplen_ff == {CAPW{1'b0}}) ?
  {{(CAPW-1){1'b0}}, 1'b1} : caplen_ff;

// Reloaded on every entry to waiting, so each completed capture
// restarts the auto wait from its full length.
trig_count #(.W(TOW)) u_auto
(
  .i_ref_clk(i_ref_clk),
  .i_srst(i_srst),
  .i_load(enter_arm),
  .i_load_val(auto_ff),
  .i_step(in_arm),
  .o_zero(to_zero),
  .o_last()
);

trig_count #(.W(CAPW)) u_cap
(
  .i_ref_clk(i_ref_clk),
  .i_srst(i_srst),
  .i_load(enter_capt),
  .i_load_val(cap_load),
  .i_step(in_capt && i_smp_valid),
  .o_zero(cap_zero),
  .o_last(cap_last)
);

// Mode none passes through waiting for one cycle between frames, so
// the auto timer and the frame counter see the same entry points.
always @*
begin
  nxt_state = state_ff;
  case (state_ff)
    ST_IDLE:
    begin
      if (run)
        nxt_state = ST_ARM;
    end
    ST_ARM:
    begin
      if (!run)
        nxt_state = ST_IDLE;
      else if (mode == `MODE_NONE)
        nxt_state = ST_CAPT;
      else if (got_trig)
        nxt_state = ST_CAPT;
      else if (auto_exp)
        nxt_state = ST_CAPT;
    end
    ST_CAPT:
    begin
      if (!run)
        nxt_state = ST_IDLE;
      else if (frame_end && (mode == `MODE_SINGLE) && frame_trig_ff)
        nxt_state = ST_HALT;
      else if (frame_end)
        nxt_state = ST_ARM;
    end
    ST_HALT:
    begin
      if (!run)
        nxt_state = ST_IDLE;
      else if (rearm)
        nxt_state = ST_ARM;
    end
    default:
      nxt_state = ST_IDLE;
  endcase
end

always @(posedge i_ref_clk)
begin
  if (i_srst)
  begin
    state_ff <= ST_IDLE;
    frame_trig_ff <= 1'b0;
    last_smp_ff <= {W{1'b0}};
    trigval_ff <= {W{1'b0}};
    trigd_ff <= 1'b0;
    forced_ff <= 1'b0;
    frames_ff <= 16'h0000;
  end
  else
  begin
    state_ff <= nxt_state;
    if (i_smp_valid)
      last_smp_ff <= sel_smp;
    if (enter_capt)
      frame_trig_ff <= got_trig;
    if (got_trig)
      trigval_ff <= last_smp_ff;
    if (frame_end)
    begin
      frames_ff <= frames_ff + 16'h0001;
      trigd_ff <= frame_trig_ff;
      forced_ff <= !frame_trig_ff && (mode == `MODE_AUTO);
    end
  end
end

// ****************************************************************
// Stream outputs.
// ****************************************************************
always @(posedge i_ref_clk)
begin
  if (i_srst)
  begin
    o_smp <= {W{1'b0}};
    o_capture <= 1'b0;
    o_trig <= 1'b0;
    o_forced <= 1'b0;
    o_frame_done <= 1'b0;
    o_update <= 1'b0;
    o_halted <= 1'b0;
  end
  else
  begin
    // The sample output follows the source every cycle; only the
    // capture pulse says which of those belong to the frame.
    o_smp <= sel_smp;
    o_capture <= in_capt && i_smp_valid;
    o_trig <= got_trig;
    o_forced <= auto_exp;
    o_frame_done <= frame_end;
    // A slow time base shows each sample as it lands instead of
    // waiting for the frame; triggering itself is unaffected.
    o_update <= slow ? (in_capt && i_smp_valid) : frame_end;
    o_halted <= (nxt_state == ST_HALT);
  end
end

// ****************************************************************
// APB slave.
// ****************************************************************
// Every transfer gets exactly one wait state: pready is registered
// from the access phase, and a write commits when it is seen high.
always @*
begin
  mapped = 1'b1;
  rdata = 32'h0000_0000;
  case (i_paddr)
    `REG_CTRL: rdata[10:0] = ctrl_ff;
    `REG_THR1: rdata[W-1:0] = thr1_ff;
    `REG_THR2: rdata[W-1:0] = thr2_ff;
    `REG_AUTO: rdata[TOW-1:0] = auto_ff;
    `REG_CAPLEN: rdata[CAPW-1:0] = caplen_ff;
    `REG_STATUS:
    begin
      rdata[1:0] = state_ff;
      rdata[`STAT_TRIGD] = trigd_ff;
      rdata[`STAT_FORCED] = forced_ff;
    end
    `REG_FRAMES: rdata[15:0] = frames_ff;
    `REG_TRIGVAL: rdata[W-1:0] = trigval_ff;
    `REG_CMD: rdata = 32'h0000_0000;
    default: mapped = 1'b0;
  endcase
end

always @(posedge i_ref_clk)
begin
  if (i_srst)
  begin
    o_pready <= 1'b0;
    o_pslverr <= 1'b0;
    o_prdata <= 32'h0000_0000;
  end
  else
  begin
    o_pready <= acc;
    o_pslverr <= acc && !mapped;
    o_prdata <= (acc && !i_pwrite) ? rdata : 32'h0000_0000;
  end
end

always @(posedge i_ref_clk)
begin
  if (i_srst)
  begin
    ctrl_ff <= CTRL_RST_W[10:0];
    thr1_ff <= THR_RST_W[W-1:0];
    thr2_ff <= THR_RST_W[W-1:0];
    auto_ff <= AUTO_CYC;
    caplen_ff <= CAPLEN_RST_W[CAPW-1:0];
  end
  else if (wr)
  begin
    // Status, frame count and trigger value are read only; writes to
    // them are dropped without an error.
    case (i_paddr)
      `REG_CTRL: ctrl_ff <= i_pwdata[10:0];
      `REG_THR1: thr1_ff <= i_pwdata[W-1:0];
      `REG_THR2: thr2_ff <= i_pwdata[W-1:0];
      `REG_AUTO: auto_ff <= i_pwdata[TOW-1:0];
      `REG_CAPLEN: caplen_ff <= i_pwdata[CAPW-1:0];
      default: ctrl_ff <= ctrl_ff;
    endcase
  end
end

endmodule // scope_trigger_unit

// [rtl/trig_consts.vh]
`ifndef TRIG_CONSTS_VH
`define TRIG_CONSTS_VH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define REG_CTRL 8'h00
`define REG_THR1 8'h04
`define REG_THR2 8'h08
`define REG_AUTO 8'h0C
`define REG_CAPLEN 8'h10
`define REG_STATUS 8'h14
`define REG_FRAMES 8'h18
`define REG_TRIGVAL 8'h1C
`define REG_CMD 8'h20

// ****************************************************************
// Control, command and status field positions.
// ****************************************************************
`define CTRL_RUN 0
`define CTRL_MODE_LSB 1
`define CTRL_TYPE_LSB 3
`define CTRL_DIR_LSB 5
`define CTRL_SRC_LSB 7
`define CTRL_HYST 9
`define CTRL_SLOW 10
`define CMD_FORCE 0
`define CMD_REARM 1
`define STAT_TRIGD 2
`define STAT_FORCED 3

// ****************************************************************
// Encodings.
// ****************************************************************
`define MODE_NONE 2'h0
`define MODE_AUTO 2'h1
`define MODE_REPEAT 2'h2
`define MODE_SINGLE 2'h3
`define TYPE_EDGE 2'h0
`define TYPE_ADV 2'h1
`define TYPE_WIN 2'h2
`define DIR_RISE 2'h0
`define DIR_FALL 2'h1
`define DIR_BOTH 2'h2

// ****************************************************************
// Reset values and timing.
// ****************************************************************
`define CTRL_RST 32'h0000_0000
`define THR_RST 32'h0000_0000
`define CAPLEN_RST 32'h0000_0400
`define CLK_HZ 10000000
`define AUTO_WAIT_MS 100
`define AUTO_WAIT_CYC (`AUTO_WAIT_MS * (`CLK_HZ / 1000))

`endif

// [rtl/trig_count.v]
`timescale 1ns/10ps
`include "trig_consts.vh"

// Down counter that stops at zero.
module trig_count
#(
  parameter W = 24
)
(
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_load,
  input wire [W-1:0] i_load_val,
  input wire i_step,
  output wire o_zero,
  output wire o_last
);

reg [W-1:0] cnt_ff;

always @(posedge i_ref_clk)
begin
  if (i_srst)
  begin
    cnt_ff <= {W{1'b0}};
  end
  else if (i_load)
  begin
    cnt_ff <= i_load_val;
  end
  else if (i_step && (cnt_ff != {W{1'b0}}))
  begin
    cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
  end
end

assign o_zero = (cnt_ff == {W{1'b0}});
assign o_last = (cnt_ff == {{(W-1){1'b0}}, 1'b1});

endmodule // trig_count

// [rtl/trig_detect.v]
`timescale 1ns/10ps
`include "trig_consts.vh"

// Crossing detector for one sample stream; fire is a registered pulse.
module trig_detect
#(
  parameter W = 12
)
(
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_valid,
  input wire signed [W-1:0] i_smp,
  input wire signed [W-1:0] i_thr1,
  input wire signed [W-1:0] i_thr2,
  input wire [1:0] i_type,
  input wire [1:0] i_dir,
  input wire i_hyst,
  output reg o_fire
);

reg signed [W-1:0] prev_ff;
reg have_ff;
reg arm_up_ff;
reg arm_dn_ff;
wire up = have_ff && (prev_ff < i_thr1) && (i_smp >= i_thr1);
wire dn = have_ff && (prev_ff >= i_thr1) && (i_smp < i_thr1);
wire use_hyst = i_hyst && (i_type == `TYPE_ADV);
wire in_now = (i_smp <= i_thr1) && (i_smp >= i_thr2);
wire in_prev = (prev_ff <= i_thr1) && (prev_ff >= i_thr2);
wire enter = have_ff && in_now && !in_prev;
wire leave = have_ff && !in_now && in_prev;
wire up_ok = up && (!use_hyst || arm_up_ff);
wire dn_ok = dn && (!use_hyst || arm_dn_ff);
reg hit;

always @*
begin
  hit = 1'b0;
  if (i_type == `TYPE_WIN)
  begin
    case (i_dir)
      `DIR_RISE: hit = enter;
      `DIR_FALL: hit = leave;
      default: hit = enter || leave;
    endcase
  end
  else
  begin
    case (i_dir)
      `DIR_RISE: hit = up_ok;
      `DIR_FALL: hit = dn_ok;
      default: hit = (i_type == `TYPE_ADV) && (up_ok || dn_ok);
    endcase
  end
end

always @(posedge i_ref_clk)
begin
  if (i_srst)
  begin
    prev_ff <= {W{1'b0}};
    have_ff <= 1'b0;
    arm_up_ff <= 1'b0;
    arm_dn_ff <= 1'b0;
    o_fire <= 1'b0;
  end
  else
  begin
    o_fire <= i_valid && hit;
    if (i_valid)
    begin
      prev_ff <= i_smp;
      have_ff <= 1'b1;
      // Arming needs the second threshold first; firing disarms.
      if (!use_hyst || up)
        arm_up_ff <= 1'b0;
      else if (i_smp < i_thr2)
        arm_up_ff <= 1'b1;
      if (!use_hyst || dn)
        arm_dn_ff <= 1'b0;
      else if (i_smp > i_thr2)
        arm_dn_ff <= 1'b1;
    end
  end
end

endmodule // trig_detect

// [sim/trig_src_model.sv]
`timescale 1ns/10ps
// ****
// Channel converter stand-in.
// ****
module trig_src_model
(
  input wire logic i_ref_clk,
  input wire logic i_go,
  input wire logic [47:0] i_set,
  output logic o_smp_valid,
  output logic [47:0] o_smp_data
);
  // Between strobes the data toggles, so a stale read shows up as garbage.
  initial o_smp_valid = 1'b0;
  initial o_smp_data = 48'h0;
  always @(posedge i_ref_clk)
  begin
    o_smp_valid <= i_go;
    o_smp_data <= i_go ? i_set : ~o_smp_data;
  end
endmodule // trig_src_model

// [sim/scope_trigger_unit_chk.sv]
`timescale 1ns/10ps
// ****
// Port checker.
// ****
module scope_trigger_unit_chk
(
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_psel,
  input wire i_penable,
  input wire o_pready,
  input wire i_smp_valid,
  input wire o_capture,
  input wire o_trig,
  input wire o_forced,
  input wire o_frame_done,
  input wire o_update,
  input wire o_halted
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  sequence s_req;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_ans;
    o_pready ##1 !o_pready;
  endsequence
  AST_APB_ANSWER: assert property (s_req |=> s_ans)
    else $error("bus answer late");
  AST_CAP_SAMPLE: assert property (o_capture |-> $past(i_smp_valid))
    else $error("capture without sample");
  AST_TRIG_ONCE: assert property (o_trig |=> !o_trig)
    else $error("trigger held");
  AST_TRIG_NO_CAP: assert property (o_trig |-> !o_capture)
    else $error("capture with trigger");
  AST_HALT_STAYS: assert property (o_halted && !i_psel |=> o_halted)
    else $error("halt left alone");
  AST_HALT_QUIET: assert property ($past(o_halted) && o_halted
    |-> !o_capture && !o_trig)
    else $error("activity while halted");
  AST_UPDATE: assert property (o_update |-> o_capture || o_frame_done)
    else $error("update without cause");
  AST_FORCED: assert property (o_forced |-> !o_trig && !o_capture)
    else $error("forced frame clash");
  AST_DONE: assert property (o_frame_done
    |-> $past(i_smp_valid) || $past(i_smp_valid, 2))
    else $error("frame end without sample");
endmodule // scope_trigger_unit_chk

// [sim/scope_trigger_unit_test.sv]
`timescale 1ns/10ps
`include "trig_consts.vh"
// ****
// Bench top.
// ****
module scope_trigger_unit_test;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic go = 1'b0;
  logic [47:0] set = 48'h0;
  logic [31:0] o_prdata, rd;
  logic [47:0] i_smp_data;
  logic [11:0] o_smp;
  logic o_pready, o_pslverr, i_smp_valid, o_capture, o_trig, o_forced;
  logic o_frame_done, o_update, o_halted, er;
  int fails = 0;
  int n_compared = 0;
  int n_trig = 0, n_cap = 0, n_done = 0, n_frc = 0, n_upd = 0;
  always #50 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    n_trig <= n_trig + 32'(o_trig);
    n_cap <= n_cap + 32'(o_capture);
    n_done <= n_done + 32'(o_frame_done);
    n_frc <= n_frc + 32'(o_forced);
    n_upd <= n_upd + 32'(o_update);
  end
  scope_trigger_unit #(.AUTO_CYC(24'h32)) u_scope_trigger_unit (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_smp_valid(i_smp_valid),
    .i_smp_data(i_smp_data), .o_smp(o_smp), .o_capture(o_capture),
    .o_trig(o_trig), .o_forced(o_forced), .o_frame_done(o_frame_done),
    .o_update(o_update), .o_halted(o_halted));
  trig_src_model u_trig_src_model (.i_ref_clk(i_ref_clk), .i_go(go),
    .i_set(set), .o_smp_valid(i_smp_valid), .o_smp_data(i_smp_data));
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge i_ref_clk);
      k++;
    end
    while (o_pready !== 1'b1 && k < 20);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k >= 20)
    begin
      fails++;
      give_verdict();
    end
  endtask
  // Other channels carry the negated value, so a wrong source shows.
  task automatic smp(input logic [11:0] v, input int src);
    @(posedge i_ref_clk);
    go <= 1'b1;
    for (int c = 0; c < 4; c++)
      set[c*12 +: 12] <= (c == src) ? v : -v;
    @(posedge i_ref_clk);
    go <= 1'b0;
    @(posedge i_ref_clk);
    #1 chk("sample", {20'h0, v}, {20'h0, o_smp});
    repeat (5) @(posedge i_ref_clk);
  endtask
  function automatic logic [31:0] ctl(input int m, t, d, s, h, w);
    return 32'(1 + 2*m + 8*t + 32*d + 128*s + 512*h + 1024*w);
  endfunction
  // The prime sample goes in while stopped, so it only sets the history.
  task automatic run4(input logic [31:0] c, input logic [11:0] t1, t2, p,
    s1, s2, s3, input int src, ex);
    int bt, bd;
    apb(1'b1, `REG_THR1, {{20{t1[11]}}, t1});
    apb(1'b1, `REG_THR2, {{20{t2[11]}}, t2});
    apb(1'b1, `REG_CTRL, c & 32'hFFFF_FFFE);
    smp(p, src);
    apb(1'b1, `REG_CTRL, c);
    bt = n_trig;
    bd = n_done;
    smp(s1, src);
    smp(s2, src);
    smp(s3, src);
    smp(s3, src);
    chk("triggers", 32'(ex), 32'(n_trig - bt));
    chk("frames", 32'(ex), 32'(n_done - bd));
  endtask
  task automatic t_regs;
    apb(1'b0, `REG_CAPLEN, 32'h0);
    chk("caplen reset", `CAPLEN_RST, rd);
    apb(1'b0, `REG_AUTO, 32'h0);
    chk("auto reset", 32'h32, rd);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, `REG_CAPLEN, 32'h1);
    apb(1'b0, `REG_CAPLEN, 32'h0);
    chk("caplen", 32'h1, rd);
  endtask
  task automatic t_edge;
    run4(ctl(2, 0, 0, 2, 0, 0), 0, 0, 12'hFFB, 5, 12'hFFB, 5, 2, 2);
    run4(ctl(2, 0, 1, 1, 0, 0), 0, 0, 5, 12'hFFB, 5, 12'hFFB, 1, 2);
    run4(ctl(2, 0, 2, 0, 0, 0), 0, 0, 12'hFFB, 5, 12'hFFB, 5, 0, 0);
    run4(ctl(2, 1, 2, 3, 0, 0), 0, 0, 12'hFFB, 5, 5, 12'hFFB, 3, 2);
    run4(ctl(2, 1, 0, 0, 1, 0), 0, 12'hFF0, 12'hFFB, 5, 12'hFEC, 5, 0,
      1);
  endtask
  task automatic t_win;
    run4(ctl(2, 2, 0, 0, 0, 0), 12'h020, 12'hFE0, 100, 0, 100, 0, 0, 2);
    run4(ctl(2, 2, 1, 0, 0, 0), 12'h020, 12'hFE0, 0, 100, 0, 12'hF9C, 0,
      2);
    run4(ctl(2, 2, 2, 0, 0, 0), 12'h020, 12'hFE0, 100, 0, 0, 12'hF9C, 0,
      2);
  endtask
  task automatic t_single;
    run4(ctl(3, 0, 0, 0, 0, 0), 0, 0, 12'hFFB, 5, 12'hFFB, 5, 0, 1);
    chk("halted", 32'h1, {31'h0, o_halted});
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("status", 32'h7, rd);
    apb(1'b1, `REG_CMD, 32'h2);
    @(posedge i_ref_clk);
    chk("rearmed", 32'h0, {31'h0, o_halted});
  endtask
  task automatic t_auto;
    // Stop first, so entering the wait loads the new length.
    apb(1'b1, `REG_CTRL, 32'h0);
    apb(1'b1, `REG_AUTO, 32'h14);
    apb(1'b1, `REG_CTRL, ctl(1, 0, 0, 0, 0, 0));
    repeat (40) @(posedge i_ref_clk);
    chk("forced", 32'h1, 32'(n_frc));
    smp(0, 0);
    repeat (35) @(posedge i_ref_clk);
    chk("forced again", 32'h2, 32'(n_frc));
  endtask
  task automatic t_slow;
    int bc, bd, bu;
    apb(1'b1, `REG_CTRL, 32'h0);
    apb(1'b1, `REG_CAPLEN, 32'h2);
    apb(1'b1, `REG_CTRL, ctl(0, 0, 0, 0, 0, 1));
    bc = n_cap;
    bd = n_done;
    bu = n_upd;
    repeat (4) smp(0, 0);
    chk("captures", 32'h4, 32'(n_cap - bc));
    chk("frames", 32'h2, 32'(n_done - bd));
    chk("updates", 32'h4, 32'(n_upd - bu));
  endtask
  initial
  begin
    repeat (3) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    t_regs();
    t_edge();
    t_win();
    t_single();
    t_auto();
    t_slow();
    give_verdict();
  end
endmodule // scope_trigger_unit_test
bind scope_trigger_unit scope_trigger_unit_chk u_scope_trigger_unit_chk (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .i_smp_valid(i_smp_valid),
  .o_capture(o_capture), .o_trig(o_trig), .o_forced(o_forced),
  .o_frame_done(o_frame_done), .o_update(o_update), .o_halted(o_halted));
